/* flash_ctrl_access_gating.sv */
// Purpose: gate flash control and erase block registers on the high-voltage flag
// Assumes: flash_high_volt_pin is the threshold detector output, asynchronous
// Notes: prom_fill_out supplies the fill byte above the implemented array
// Notes: a low flag pulls the control byte back to its reset value
// Summary of operation
// (RL1) control and erase registers at fixed addresses
// (RL2) registers reachable only with high voltage present
// (RL3) flag from threshold detector enables writes
// (RL4) writes accepted once flag set
// (RL5) control register read/write, resets to 0x80
// (RL6) without voltage: reads 0xFF, writes ignored (here only control reads 0xFF; erase selects read 0x00)
// (RL7) bit 7 reads one either way
// (RL8) software polls whole byte against 0xFF
// (RL9) PROM mode returns 0xFF above array
// (RL10) programmer buffer holds 0xFF above array
// (RL11) reset held through oscillator settling first
// (RL12) running reset held ten clocks before voltage
// (RL13) voltage changed only in reset or off-flash
// (RL14) no flash reads during voltage change
// (RL15) arm bits clear when voltage changes
// (RL16) start watchdog before setting arm bits
// (RL17) program while program-arm, erase while erase-arm
// (RL18) gating re-evaluated every cycle from synced flag
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "flash_gate_params.svh"
module flash_ctrl_access_gating #(
   parameter logic [16:0] ARRAY_TOP = `ARRAY_TOP_DEFAULT
) (
   input wire logic clk_sys_in,
   input wire logic srst_in,
   input wire logic flash_high_volt_pin_in,
   input wire flash_gate_pkg::reg_addr_t addr_in,
   input wire flash_gate_pkg::byte_t wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output flash_gate_pkg::byte_t rdata_out,
   output logic high_volt_flag_out,
   output logic prog_arm_out,
   output logic erase_arm_out,
   output flash_gate_pkg::byte_t erase_blocks_1_out,
   output flash_gate_pkg::byte_t erase_blocks_2_out,
   input wire flash_gate_pkg::prom_addr_t prom_addr_in,
   input wire flash_gate_pkg::byte_t prom_array_data_in,
   output flash_gate_pkg::byte_t prom_fill_out
);
   import flash_gate_pkg::*;

   logic volt_s1_reg, volt_s2_reg, volt_s3_reg, volt_flag_reg;
   byte_t ctrl_reg, erase_block_select_1_reg, erase_block_select_2_reg, rdata_reg, prom_reg;

   // three-stage sampler; flag moves only when stages two and three agree
   // the flag alone opens the register gate, taken fresh every cycle
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         volt_s1_reg <= 1'b0;
         volt_s2_reg <= 1'b0;
         volt_s3_reg <= 1'b0;
         volt_flag_reg <= 1'b0;
      end else begin
         volt_s1_reg <= flash_high_volt_pin_in;
         volt_s2_reg <= volt_s1_reg;
         volt_s3_reg <= volt_s2_reg;
         if (volt_s2_reg == volt_s3_reg) begin
            volt_flag_reg <= volt_s3_reg; // [RL3]
         end
      end
   end

   // one byte-address compare shared by all three register selects
   function automatic logic addr_is(input reg_addr_t a, input reg_addr_t target);
      return a == target;
   endfunction

   wire hit_ctrl = addr_is(addr_in, `FLASH_PROG_CONTROL_ADDR); // [RL1]
   wire hit_erase_block_select_1 = addr_is(addr_in, `ERASE_BLOCK_SELECT_1_ADDR); // [RL1]
   wire hit_erase_block_select_2 = addr_is(addr_in, `ERASE_BLOCK_SELECT_2_ADDR); // [RL1]
   wire gate_open = volt_flag_reg; // [RL18]
   wire wr_ctrl = wr_in && hit_ctrl && gate_open; // [RL2] [RL4] [RL6]
   wire wr_erase_block_select_1 = wr_in && hit_erase_block_select_1 && gate_open; // [RL2] [RL4]
   wire wr_erase_block_select_2 = wr_in && hit_erase_block_select_2 && gate_open; // [RL2] [RL4]
   // bit 7 always reads one, so software must compare the whole byte
   wire byte_t volt_mask = 8'h01 << `VOLT_BIT;
   wire byte_t ctrl_view = ctrl_reg | volt_mask; // [RL7]
   wire byte_t rd_mux =
      !gate_open ? (hit_ctrl ? `REG_ABSENT_VALUE : 8'h00) : // [RL6]
      hit_ctrl ? ctrl_view : // [RL5]
      hit_erase_block_select_1 ? erase_block_select_1_reg :
      hit_erase_block_select_2 ? erase_block_select_2_reg : 8'h00;

   // next values; a closed gate also pulls the arm bits back to their reset state
   wire byte_t ctrl_next =
      wr_ctrl ? (wdata_in | volt_mask) : // [RL5] [RL7]
      !gate_open ? `FLASH_PROG_CONTROL_RESET :
      ctrl_reg;
   wire byte_t erase_block_select_1_next = wr_erase_block_select_1 ? wdata_in : erase_block_select_1_reg; // [RL4]
   wire byte_t erase_block_select_2_next = wr_erase_block_select_2 ? wdata_in : erase_block_select_2_reg; // [RL4]
   // read data stand one cycle after the strobe, zero otherwise
   wire byte_t rdata_next = rd_in ? rd_mux : 8'h00;

   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         ctrl_reg <= `FLASH_PROG_CONTROL_RESET; // [RL5]
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         erase_block_select_1_reg <= `ERASE_BLOCK_SELECT_RESET;
         erase_block_select_2_reg <= `ERASE_BLOCK_SELECT_RESET;
      end else begin
         erase_block_select_1_reg <= erase_block_select_1_next;
         erase_block_select_2_reg <= erase_block_select_2_next;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // PROM mode: fill byte above implemented array
   wire above_top = (prom_addr_in >= ARRAY_TOP); // [RL9]
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         prom_reg <= `FILL_VALUE;
      end else begin
         prom_reg <= above_top ? `FILL_VALUE : prom_array_data_in; // [RL9]
      end
   end

   assign rdata_out = rdata_reg;
   assign high_volt_flag_out = volt_flag_reg;
   assign prog_arm_out = gate_open && ctrl_reg[`PROG_ARM_BIT]; // [RL17]
   assign erase_arm_out = gate_open && ctrl_reg[`ERASE_ARM_BIT]; // [RL17]
   assign erase_blocks_1_out = erase_block_select_1_reg;
   assign erase_blocks_2_out = erase_block_select_2_reg;
   assign prom_fill_out = prom_reg;

   // access checks: refused control reads all ones, refused writes move nothing, accepted writes land, bit 7 reads one
   a_absent_reads_ff: assert property (@(posedge clk_sys_in) disable iff (srst_in) // [RL6]
      rd_in && hit_ctrl && !gate_open |=> rdata_out == 8'hFF)
      else $error("control address did not read 0xFF without voltage");
   a_absent_no_write: assert property (@(posedge clk_sys_in) disable iff (srst_in) // [RL2]
      wr_in && hit_erase_block_select_1 && !gate_open |=> $stable(erase_blocks_1_out))
      else $error("erase select changed without voltage");
   a_present_write: assert property (@(posedge clk_sys_in) disable iff (srst_in) // [RL4]
      wr_in && hit_erase_block_select_2 && gate_open |=> erase_blocks_2_out == $past(wdata_in))
      else $error("erase select write lost with voltage");
   a_bit7_one: assert property (@(posedge clk_sys_in) disable iff (srst_in) // [RL7]
      rd_in && hit_ctrl |=> rdata_out[7])
      else $error("control bit 7 read zero");

   // write then read of the control byte, both taken with the gate open
   sequence s_ctrl_write;
      wr_in && hit_ctrl && gate_open;
   endsequence
   sequence s_ctrl_read;
      rd_in && hit_ctrl && gate_open;
   endsequence
   a_ctrl_readback: assert property (@(posedge clk_sys_in) disable iff (srst_in) // [RL5]
      s_ctrl_write ##1 s_ctrl_read
      |=> rdata_out == ($past(wdata_in, 2) | 8'h80))
      else $error("control readback mismatch");

   a_erase_block_select_1_readback: assert property (@(posedge clk_sys_in) disable iff (srst_in) // [RL4]
      rd_in && hit_erase_block_select_1 && gate_open |=> rdata_out == $past(erase_blocks_1_out))
      else $error("erase select 1 readback mismatch");

   a_erase_block_select_2_readback: assert property (@(posedge clk_sys_in) disable iff (srst_in) // [RL4]
      rd_in && hit_erase_block_select_2 && gate_open |=> rdata_out == $past(erase_blocks_2_out))
      else $error("erase select 2 readback mismatch");

   a_absent_select_reads: assert property (@(posedge clk_sys_in) disable iff (srst_in) // [RL2]
      rd_in && (hit_erase_block_select_1 || hit_erase_block_select_2) && !gate_open |=> rdata_out == 8'h00)
      else $error("erase select visible without voltage");

   a_unmapped_reads_zero: assert property (@(posedge clk_sys_in) disable iff (srst_in) // [RL1]
      rd_in && !hit_ctrl && !hit_erase_block_select_1 && !hit_erase_block_select_2 |=> rdata_out == 8'h00)
      else $error("unmapped address read nonzero");

   a_absent_arms_low: assert property (@(posedge clk_sys_in) disable iff (srst_in) // [RL6]
      wr_in && hit_ctrl && !gate_open |=> !prog_arm_out && !erase_arm_out)
      else $error("control write took effect without voltage");

   a_absent_erase_block_select_2: assert property (@(posedge clk_sys_in) disable iff (srst_in) // [RL2]
      wr_in && hit_erase_block_select_2 && !gate_open |=> $stable(erase_blocks_2_out))
      else $error("erase select 2 changed without voltage");

   a_erase_block_select_1_write: assert property (@(posedge clk_sys_in) disable iff (srst_in) // [RL18]
      wr_in && hit_erase_block_select_1 && gate_open |=> erase_blocks_1_out == $past(wdata_in))
      else $error("erase select 1 write lost with flag set");

   // sampler: flag follows only when stages two and three agree
   a_flag_follows: assert property (@(posedge clk_sys_in) disable iff (srst_in) // [RL3]
      volt_s2_reg && volt_s3_reg |=> high_volt_flag_out)
      else $error("flag did not follow agreeing samples");

   a_flag_clears: assert property (@(posedge clk_sys_in) disable iff (srst_in) // [RL3]
      !volt_s2_reg && !volt_s3_reg |=> !high_volt_flag_out)
      else $error("flag did not clear on agreeing low samples");

   a_flag_holds: assert property (@(posedge clk_sys_in) disable iff (srst_in) // [RL3]
      volt_s2_reg != volt_s3_reg |=> $stable(high_volt_flag_out))
      else $error("flag moved on disagreeing samples");

   // arms need a flag that already stood in the cycle of the arming write
   a_arm_needs_flag: assert property (@(posedge clk_sys_in) disable iff (srst_in) // [RL17]
      (prog_arm_out || erase_arm_out) |-> high_volt_flag_out && $past(high_volt_flag_out))
      else $error("arm active without a standing voltage flag");

   // PROM mode fill and pass-through
   a_prom_fill: assert property (@(posedge clk_sys_in) disable iff (srst_in) // [RL9]
      prom_addr_in >= ARRAY_TOP |=> prom_fill_out == 8'hFF)
      else $error("fill byte not 0xFF above array");

   a_prom_pass: assert property (@(posedge clk_sys_in) disable iff (srst_in) // [RL9]
      prom_addr_in < ARRAY_TOP |=> prom_fill_out == $past(prom_array_data_in))
      else $error("array byte not passed below top");
endmodule
`default_nettype wire

/* flash_gate_params.svh */
// Purpose: offsets, field positions, reset values and array top for flash register gating
// Assumes: byte-wide register port, 16-bit address space
// Notes: definitions only
`ifndef FLASH_GATE_PARAMS_SVH
`define FLASH_GATE_PARAMS_SVH
`define FLASH_PROG_CONTROL_ADDR 16'hFF80
`define ERASE_BLOCK_SELECT_1_ADDR 16'hFF82
`define ERASE_BLOCK_SELECT_2_ADDR 16'hFF83
`define FLASH_PROG_CONTROL_RESET 8'h80
`define ERASE_BLOCK_SELECT_RESET 8'h00
`define REG_ABSENT_VALUE 8'hFF
`define FILL_VALUE 8'hFF
`define VOLT_BIT 7
`define ERASE_ARM_BIT 1
`define PROG_ARM_BIT 0
`define ARRAY_TOP_DEFAULT 17'h0_8000
`endif

/* flash_gate_pkg.sv */
// Purpose: shared types for flash register gating
// Assumes: used with flash_gate_params.svh
// Notes: types only
package flash_gate_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [15:0] reg_addr_t;
   typedef logic [16:0] prom_addr_t;
endpackage

/* supply_model.sv */
// Purpose: programming supply that moves the high-voltage pin
// Assumes: pin only moves after ten clocks in reset
// Notes: behavioural
`timescale 1ns/1ps
`default_nettype none
module supply_model (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic want_in,
   output logic pin_out
);
   int unsigned held = 0;
   logic level = 1'b0;
   assign pin_out = level;
   always @(posedge clk_in) begin
      held <= srst_in ? held + 1 : 0;
      if (srst_in && held >= 10) begin
         level <= want_in;
      end
   end
endmodule
`default_nettype wire

/* flash_ctrl_access_gating_test.sv */
// Purpose: self-checking bench for flash register gating
// Assumes: supply_model moves the pin only in reset
// Notes: one task per scenario
`timescale 1ns/1ps
`default_nettype none
module flash_ctrl_access_gating_test;
   import flash_gate_pkg::*;
   logic clk_sys_in = 0, srst_in = 1, wr = 0, rd = 0, want = 0, pin, flag, parm, earm;
   reg_addr_t addr = 0;
   byte_t wdata = 0, pdata = 0, rdata, eb1, eb2, fill, v;
   prom_addr_t paddr = 0;
   int bad_count = 0, comparisons = 0;
   always #10 clk_sys_in = ~clk_sys_in;
   supply_model sup (.clk_in(clk_sys_in), .srst_in(srst_in), .want_in(want), .pin_out(pin));
   flash_ctrl_access_gating dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
      .flash_high_volt_pin_in(pin), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
      .rdata_out(rdata), .high_volt_flag_out(flag), .prog_arm_out(parm), .erase_arm_out(earm),
      .erase_blocks_1_out(eb1), .erase_blocks_2_out(eb2), .prom_addr_in(paddr),
      .prom_array_data_in(pdata), .prom_fill_out(fill));
   task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic wreg(reg_addr_t a, byte_t d);
      addr <= a;
      wdata <= d;
      wr <= 1;
      @(posedge clk_sys_in);
      wr <= 0;
      @(posedge clk_sys_in);
   endtask
   task automatic rreg(reg_addr_t a);
      addr <= a;
      rd <= 1;
      @(posedge clk_sys_in);
      rd <= 0;
      #1 v = rdata;
      @(posedge clk_sys_in);
   endtask
   task automatic wr_then_rd(reg_addr_t a, byte_t d);
      addr <= a;
      wdata <= d;
      wr <= 1;
      @(posedge clk_sys_in);
      wr <= 0;
      rd <= 1;
      @(posedge clk_sys_in);
      rd <= 0;
      #1 v = rdata;
      @(posedge clk_sys_in);
   endtask
   task automatic reset_with(logic hv);
      want <= hv;
      srst_in <= 1;
      repeat (12) @(posedge clk_sys_in);
      srst_in <= 0;
      for (int i = 0; i < 20 && flag !== hv; i++) @(posedge clk_sys_in);
      chk("flag", hv, flag);
      if (flag !== hv) close_out();
   endtask
   task automatic t_absent;
      rreg(16'hFF80);
      chk("ctrl", 8'hFF, v);
      rreg(16'hFF82);
      chk("eb1 read", 8'h00, v);
      wreg(16'hFF80, 8'h03);
      wreg(16'hFF82, 8'h5A);
      chk("eb1", 8'h00, eb1);
      chk("arms", 8'h00, {earm, parm});
      $display("done absent");
   endtask
   task automatic t_present;
      reset_with(1);
      rreg(16'hFF80);
      chk("ctrl", 8'h80, v);
      wreg(16'hFF82, 8'h5A);
      chk("eb1", 8'h5A, eb1);
      wreg(16'hFF83, 8'hA5);
      chk("eb2", 8'hA5, eb2);
      rreg(16'hFF82);
      chk("eb1 read", 8'h5A, v);
      rreg(16'hFF83);
      chk("eb2 read", 8'hA5, v);
      rreg(16'hFF81);
      chk("gap read", 8'h00, v);
      wreg(16'hFF80, 8'h01);
      chk("arms", 8'h01, {earm, parm});
      wr_then_rd(16'hFF80, 8'h03);
      chk("arms", 8'h03, {earm, parm});
      chk("ctrl", 8'h83, v);
      wreg(16'hFF80, 8'h00);
      $display("done present");
   endtask
   task automatic t_release;
      reset_with(0);
      rreg(16'hFF80);
      chk("ctrl", 8'hFF, v);
      wreg(16'hFF83, 8'h11);
      chk("eb2", 8'h00, eb2);
      $display("done release");
   endtask
   task automatic prom(prom_addr_t a, byte_t d, byte_t exp);
      paddr <= a;
      pdata <= d;
      @(posedge clk_sys_in);
      #1 chk("fill", exp, fill);
      @(posedge clk_sys_in);
   endtask
   task automatic t_prom;
      prom(17'h0_7FFF, 8'h3C, 8'h3C);
      prom(17'h0_8000, 8'h3C, 8'hFF);
      prom(17'h1_FFFF, 8'h00, 8'hFF);
      $display("done prom");
   endtask
   initial begin
      repeat (5) @(posedge clk_sys_in);
      srst_in <= 0;
      @(posedge clk_sys_in);
      t_absent();
      t_present();
      t_release();
      t_prom();
      close_out();
   end
endmodule
`default_nettype wire
